// ### include/auc_map.svh
// Named offsets, field positions, opcodes and timing figures of the converter control block.
// Assumes inclusion by bare name from every file that needs them; definitions only.
`ifndef AUC_MAP_SVH
`define AUC_MAP_SVH

// System clock period and time scaling.
`define AUC_CLK_NS 40
`define AUC_NS_PER_US 1000
`define AUC_X10 10

// Reset and start-up times.
`define AUC_POR_US 600
`define AUC_START_NORM_X10 285
`define AUC_START_TURBO_X10 1050

// Interface idle timeout, in modulator periods.
`define AUC_TIMEOUT_NORM 32760
`define AUC_TIMEOUT_TURBO 65520

// Modulator clock dividers and conversion length.
`define AUC_MOD_DIV_NORM 4
`define AUC_MOD_DIV_TURBO 2
`define AUC_CONV_TICKS 256
`define AUC_DR_MAX 3'h6

// Baud measurement over the sync byte: falling edges after the start edge, and eight bits.
`define AUC_SYNC_FALLS 3'h3
`define AUC_SYNC_SHIFT 3

// Ready pulse length, in system clock periods.
`define AUC_RDY_PULSE 2

// Command opcodes.
`define AUC_OP_RESET 7'h03
`define AUC_OP_START 7'h04
`define AUC_OP_SLEEP 7'h01
`define AUC_OP_RDATA 4'h1
`define AUC_OP_RREG 4'h2
`define AUC_OP_WREG 4'h4

// Configuration registers and fields.
`define AUC_REG_CNT 5
`define AUC_REG_MODE 3'h1
`define AUC_REG_PIN 3'h4
`define AUC_REG_NORESTART 3'h4
`define AUC_CFG_RST 8'h00
`define AUC_F_DR_HI 7
`define AUC_F_DR_LO 5
`define AUC_F_TURBO 4
`define AUC_F_CM 3
`define AUC_F_PDIR 6
`define AUC_F_PSEL 3
`define AUC_F_PDAT 2

// Frame layout: start, eight data bits, stop.
`define AUC_FRAME_LAST 4'h9

`endif

// ### include/auc_pkg.sv
// Types shared by the converter control block.
// Assumes auc_map.svh supplies all numeric constants.
package auc_pkg;

	typedef enum logic [3:0] {
		CV_OFF = 4'b0001,
		CV_DLY = 4'b0010,
		CV_RUN = 4'b0100,
		CV_PUSH = 4'b1000
	} auc_conv_e;

	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_SYNC = 5'b00010,
		RX_WAIT = 5'b00100,
		RX_DATA = 5'b01000,
		RX_STOP = 5'b10000
	} auc_rx_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} auc_tx_e;

endpackage : auc_pkg

// ### hw/auc_fifo.sv
// Result buffer: a small FIFO with valid and ready on both sides and registered read data.
// Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module auc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import auc_pkg::*;
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q, rd_ptr_q, rd_ptr_d;
	logic [AW:0] cnt_q;
	logic push, pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign rd_ptr_d = pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;

	// Pointers and count; pointers wrap naturally at a power-of-two depth.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage has no reset so it can map onto plain memory cells.
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	// Head word is registered; a write into an emptying buffer bypasses the array.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			out_data <= '0;
		else if (push && (cnt_q - (AW+1)'(pop)) == '0)
			out_data <= in_data;
		else
			out_data <= mem_q[rd_ptr_d];
	end

endmodule : auc_fifo

// ### hw/auc_ctrl.sv
// Converter control: reset sources, conversion sequencing, operating modes and the UART link.
// Assumes the link pins are synchronous to ref_clk and the analog result is stable at push.
// Functional notes
// - Power-on, pin and command resets act alike.
// - Reset restores defaults, powers down until start.
// - Power-on reset releases after 600 us.
// - Command 06h or 07h resets the device.
// - Single-shot: one conversion, then low power.
// - Register write except 04h restarts conversion.
// - Continuous: buffer result, start next at once.
// - First conversion after 28.5 or 105 clocks.
// - Sleep finishes conversion, keeps registers, answers commands.
// - Start in power-down wakes and converts.
// - Normal mode: modulator at clock over four.
// - Turbo mode: modulator twice as fast.
// - Half duplex; transmit line high when idle.
// - Ready on shared pin when output and selected.
// - Unread result: ready pulses high two clocks, in continuous mode only.
// - Frames are start, eight LSB-first bits, stop.
// - Sync byte 55h precedes every command.
// - Idle mid-command past timeout resets interface.
// - Results are 16-bit two's complement words.
// - Decode start 0000100x, sleep 0000001x.
// - Command acts at middle of stop bit.
`timescale 1ns/1ps
`include "auc_map.svh"
module auc_ctrl #(
	parameter int POR_CYCLES = (`AUC_POR_US * `AUC_NS_PER_US + `AUC_CLK_NS - 1) / `AUC_CLK_NS,
	parameter int TIMEOUT_NORM = `AUC_TIMEOUT_NORM,
	parameter int TIMEOUT_TURBO = `AUC_TIMEOUT_TURBO,
	parameter int CONV_TICKS = `AUC_CONV_TICKS,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reset_pin_n,
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic [15:0] adc_result,
	output logic conversion_ready_n,
	output logic shared_ready_pin,
	output logic shared_ready_pin_oe,
	output logic analog_on,
	output logic modulator_tick,
	output logic conversion_mode_bit,
	output logic turbo_mode,
	output logic [2:0] data_rate_field
);
	import auc_pkg::*;
	localparam int START_NORM = (`AUC_START_NORM_X10 + `AUC_X10 - 1) / `AUC_X10;
	localparam int START_TURBO = (`AUC_START_TURBO_X10 + `AUC_X10 - 1) / `AUC_X10;

	auc_conv_e conv_q;
	auc_rx_e rx_q;
	auc_tx_e tx_q;
	logic [23:0] por_cnt_q;
	logic por_busy_q, cmd_reset_q, sys_clr;
	logic [7:0] cfg_q [`AUC_REG_CNT];
	logic [1:0] mdiv_q;
	logic [19:0] cnt_q;
	logic sleep_pend_q, rdy_n_q, pulse_q, pin_q;
	logic rx_prev_q, fall, want_data_q, byte_ok, cmd_now;
	logic [15:0] rx_cnt_q, bit_per_q, tx_cnt_q;
	logic [18:0] meas_q;
	logic [2:0] falls_q, bitn_q, wr_addr_q;
	logic [7:0] sh_q, tx_hi_q, rreg_data;
	logic [16:0] to_cnt_q;
	logic is_reset, is_start, is_sleep, is_rdata, is_rreg, wr_en, start_req;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_bits_q;
	logic tx_more_q, tx_load;
	logic fifo_push, fifo_in_ready, fifo_valid, fifo_pop;
	logic [15:0] fifo_data, last_q, tx_word;

	// Conversion length in system clocks for a given rate field and speed.
	function automatic logic [19:0] conv_len(input logic [2:0] dr, input logic tb);
		logic [2:0] d;
		d = (dr > `AUC_DR_MAX) ? `AUC_DR_MAX : dr;
		conv_len = 20'((CONV_TICKS << (`AUC_DR_MAX - d)) *
			(tb ? `AUC_MOD_DIV_TURBO : `AUC_MOD_DIV_NORM));
	endfunction : conv_len

	assign conversion_mode_bit = cfg_q[`AUC_REG_MODE][`AUC_F_CM];
	assign turbo_mode = cfg_q[`AUC_REG_MODE][`AUC_F_TURBO];
	assign data_rate_field = cfg_q[`AUC_REG_MODE][`AUC_F_DR_HI:`AUC_F_DR_LO];

	// Power-on hold: the whole block stays cleared until the counter runs out.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			por_cnt_q <= '0;
			por_busy_q <= 1'b1;
		end else if (por_busy_q) begin
			if (por_cnt_q == 24'(POR_CYCLES - 1))
				por_busy_q <= 1'b0;
			else
				por_cnt_q <= por_cnt_q + 1'b1;
		end
	end

	// All three reset sources converge on one synchronous clear.
	assign sys_clr = por_busy_q | ~reset_pin_n | cmd_reset_q;

	// Command decode at the moment the stop bit is seen.
	assign byte_ok = (rx_q == RX_STOP) && (rx_cnt_q == '0) && uart_rx;
	assign cmd_now = byte_ok && !want_data_q;
	assign is_reset = cmd_now && sh_q[7:1] == `AUC_OP_RESET;
	assign is_start = cmd_now && sh_q[7:1] == `AUC_OP_START;
	assign is_sleep = cmd_now && sh_q[7:1] == `AUC_OP_SLEEP;
	assign is_rdata = cmd_now && sh_q[7:4] == `AUC_OP_RDATA;
	assign is_rreg = cmd_now && sh_q[7:4] == `AUC_OP_RREG;
	assign wr_en = byte_ok && want_data_q;
	assign start_req = is_start ||
		(wr_en && wr_addr_q != `AUC_REG_NORESTART && conv_q != CV_OFF);
	assign rreg_data = (sh_q[3:1] < 3'(`AUC_REG_CNT)) ? cfg_q[sh_q[3:1]] : `AUC_CFG_RST;

	// The reset command takes effect one clock after its stop bit.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			cmd_reset_q <= 1'b0;
		else
			cmd_reset_q <= is_reset;
	end

	// Configuration registers; a nonexistent address is ignored.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `AUC_REG_CNT; i++)
				cfg_q[i] <= `AUC_CFG_RST;
		end else if (sys_clr) begin
			for (int i = 0; i < `AUC_REG_CNT; i++)
				cfg_q[i] <= `AUC_CFG_RST;
		end else if (wr_en && wr_addr_q < 3'(`AUC_REG_CNT)) begin
			cfg_q[wr_addr_q] <= sh_q;
		end
	end

	// Modulator enable: a quarter of the clock in normal mode, a half in turbo.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			mdiv_q <= '0;
		else if (modulator_tick || sys_clr)
			mdiv_q <= '0;
		else
			mdiv_q <= mdiv_q + 1'b1;
	end
	assign modulator_tick = mdiv_q == (turbo_mode ? 2'(`AUC_MOD_DIV_TURBO - 1) :
		2'(`AUC_MOD_DIV_NORM - 1));

	// Conversion sequencer. Sleep only takes hold once a conversion has finished.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			conv_q <= CV_OFF;
			cnt_q <= '0;
			sleep_pend_q <= 1'b0;
		end else if (sys_clr) begin
			conv_q <= CV_OFF;
			sleep_pend_q <= 1'b0;
		end else if (start_req) begin
			conv_q <= CV_DLY;
			cnt_q <= 20'(turbo_mode ? START_TURBO - 1 : START_NORM - 1);
			sleep_pend_q <= 1'b0;
		end else begin
			case (conv_q)
				CV_OFF: begin
					cnt_q <= '0;
				end
				CV_DLY: begin
					if (cnt_q == '0) begin
						conv_q <= CV_RUN;
						cnt_q <= conv_len(data_rate_field, turbo_mode) - 1'b1;
					end else
						cnt_q <= cnt_q - 1'b1;
				end
				CV_RUN: begin
					if (cnt_q == '0)
						conv_q <= CV_PUSH;
					else
						cnt_q <= cnt_q - 1'b1;
				end
				CV_PUSH: begin
					// A full buffer stalls completion until the host reads.
					if (fifo_in_ready) begin
						if (conversion_mode_bit && !sleep_pend_q) begin
							conv_q <= CV_RUN;
							cnt_q <= conv_len(data_rate_field, turbo_mode) - 1'b1;
						end else begin
							conv_q <= CV_OFF;
							sleep_pend_q <= 1'b0;
						end
					end
				end
				default: conv_q <= CV_OFF;
			endcase
			if (is_sleep && conv_q != CV_OFF)
				sleep_pend_q <= 1'b1;
		end
	end
	assign analog_on = conv_q != CV_OFF;

	// Results enter the buffer as sixteen-bit signed words.
	assign fifo_push = conv_q == CV_PUSH;
	assign fifo_pop = is_rdata && fifo_valid;

	auc_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(adc_result),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Keep the last word sent so a read of an empty buffer repeats it.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			last_q <= '0;
		else if (sys_clr)
			last_q <= '0;
		else if (fifo_pop)
			last_q <= fifo_data;
	end
	assign tx_word = fifo_valid ? fifo_data : last_q;

	// Ready goes low when a result enters the buffer, high once any word is taken for sending.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdy_n_q <= 1'b1;
			pulse_q <= 1'b0;
		end else begin
			if (sys_clr)
				rdy_n_q <= 1'b1;
			else if (fifo_push && fifo_in_ready)
				rdy_n_q <= 1'b0;
			else if (fifo_pop)
				rdy_n_q <= 1'b1;
			pulse_q <= conv_q == CV_RUN && conversion_mode_bit && !rdy_n_q &&
				cnt_q <= 20'(`AUC_RDY_PULSE) && cnt_q != '0;
		end
	end
	assign conversion_ready_n = rdy_n_q | pulse_q;

	// The shared pin carries ready only when it is an output and selected.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			pin_q <= 1'b0;
		else if (cfg_q[`AUC_REG_PIN][`AUC_F_PSEL])
			pin_q <= rdy_n_q | pulse_q;
		else
			pin_q <= cfg_q[`AUC_REG_PIN][`AUC_F_PDAT];
	end
	assign shared_ready_pin = pin_q;
	assign shared_ready_pin_oe = cfg_q[`AUC_REG_PIN][`AUC_F_PDIR];

	// Idle timeout counts modulator periods with no line activity mid-command.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			to_cnt_q <= '0;
		else if (rx_q == RX_IDLE || rx_prev_q != uart_rx || sys_clr)
			to_cnt_q <= '0;
		else if (modulator_tick)
			to_cnt_q <= to_cnt_q + 1'b1;
	end

	// Receiver: measure the sync byte, then sample each bit in its middle.
	assign fall = rx_prev_q && !uart_rx;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= RX_IDLE;
			rx_prev_q <= 1'b1;
			rx_cnt_q <= '0;
			bit_per_q <= 16'h0001;
			meas_q <= '0;
			falls_q <= '0;
			bitn_q <= '0;
			sh_q <= '0;
			want_data_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			rx_prev_q <= uart_rx;
			if (sys_clr || to_cnt_q >= 17'(turbo_mode ? TIMEOUT_TURBO : TIMEOUT_NORM)) begin
				rx_q <= RX_IDLE;
				want_data_q <= 1'b0;
			end else begin
				case (rx_q)
					RX_IDLE: begin
						if (fall) begin
							rx_q <= RX_SYNC;
							meas_q <= '0;
							falls_q <= '0;
						end
					end
					RX_SYNC: begin
						meas_q <= meas_q + 1'b1;
						if (fall) begin
							if (falls_q == `AUC_SYNC_FALLS) begin
								bit_per_q <= 16'((meas_q + 1'b1) >> `AUC_SYNC_SHIFT);
								rx_q <= RX_WAIT;
							end else
								falls_q <= falls_q + 1'b1;
						end
					end
					RX_WAIT: begin
						if (fall) begin
							rx_q <= RX_DATA;
							rx_cnt_q <= bit_per_q + (bit_per_q >> 1) - 1'b1;
							bitn_q <= '0;
						end
					end
					RX_DATA: begin
						if (rx_cnt_q == '0) begin
							sh_q <= {uart_rx, sh_q[7:1]};
							rx_cnt_q <= bit_per_q - 1'b1;
							bitn_q <= bitn_q + 1'b1;
							if (bitn_q == 3'h7)
								rx_q <= RX_STOP;
						end else
							rx_cnt_q <= rx_cnt_q - 1'b1;
					end
					RX_STOP: begin
						if (rx_cnt_q != '0)
							rx_cnt_q <= rx_cnt_q - 1'b1;
						else if (cmd_now && sh_q[7:4] == `AUC_OP_WREG) begin
							rx_q <= RX_WAIT;
							want_data_q <= 1'b1;
							wr_addr_q <= sh_q[3:1];
						end else begin
							// A bad stop bit drops the command; the next needs a fresh sync.
							rx_q <= RX_IDLE;
							want_data_q <= 1'b0;
						end
					end
					default: rx_q <= RX_IDLE;
				endcase
			end
		end
	end

	// Transmitter: ten-bit frames, words low byte first, line high when idle.
	assign tx_load = (is_rdata || is_rreg) && tx_q == TX_IDLE;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_q <= TX_IDLE;
			tx_sh_q <= '1;
			tx_bits_q <= '0;
			tx_cnt_q <= '0;
			tx_hi_q <= '0;
			tx_more_q <= 1'b0;
		end else if (sys_clr) begin
			tx_q <= TX_IDLE;
			tx_sh_q <= '1;
			tx_more_q <= 1'b0;
		end else begin
			case (tx_q)
				TX_IDLE: begin
					if (tx_load) begin
						tx_q <= TX_SEND;
						tx_sh_q <= {1'b1, is_rdata ? tx_word[7:0] : rreg_data, 1'b0};
						tx_hi_q <= tx_word[15:8];
						tx_more_q <= is_rdata;
						tx_bits_q <= `AUC_FRAME_LAST;
						tx_cnt_q <= bit_per_q - 1'b1;
					end
				end
				TX_SEND: begin
					if (tx_cnt_q != '0)
						tx_cnt_q <= tx_cnt_q - 1'b1;
					else begin
						tx_cnt_q <= bit_per_q - 1'b1;
						tx_bits_q <= tx_bits_q - 1'b1;
						tx_sh_q <= {1'b1, tx_sh_q[9:1]};
						if (tx_bits_q == '0) begin
							if (tx_more_q) begin
								tx_sh_q <= {1'b1, tx_hi_q, 1'b0};
								tx_bits_q <= `AUC_FRAME_LAST;
								tx_more_q <= 1'b0;
							end else
								tx_q <= TX_IDLE;
						end
					end
				end
				default: tx_q <= TX_IDLE;
			endcase
		end
	end
	assign uart_tx = tx_sh_q[0];

	// Helper: cycles spent in the start delay, checked against the figure.
	logic [7:0] dly_seen_q;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			dly_seen_q <= '0;
		else if (conv_q != CV_DLY || start_req)
			dly_seen_q <= '0;
		else
			dly_seen_q <= dly_seen_q + 1'b1;
	end

	a_reset_defaults: assert property (@(posedge ref_clk) disable iff (!resetn)
		sys_clr |=> conv_q == CV_OFF && !conversion_mode_bit && !analog_on)
		else $error("reset did not restore power-down defaults");
	a_cmd_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
		is_reset |-> ##2 conv_q == CV_OFF && cfg_q[`AUC_REG_MODE] == `AUC_CFG_RST)
		else $error("reset command had no effect");
	a_start_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
		conv_q == CV_DLY && $past(conv_q) == CV_DLY && !sys_clr && !start_req &&
		cnt_q == '0 |-> dly_seen_q == 8'(turbo_mode ? START_TURBO - 1 : START_NORM - 1))
		else $error("start delay length wrong");
	a_single_shot: assert property (@(posedge ref_clk) disable iff (!resetn)
		conv_q == CV_PUSH && fifo_in_ready && !conversion_mode_bit && !start_req &&
		!sys_clr |=> conv_q == CV_OFF && !analog_on)
		else $error("single-shot did not return to low power");
	a_cont_next: assert property (@(posedge ref_clk) disable iff (!resetn)
		conv_q == CV_PUSH && fifo_in_ready && conversion_mode_bit && !sleep_pend_q &&
		!is_sleep && !start_req && !sys_clr |=> conv_q == CV_RUN ##1 conv_q == CV_RUN)
		else $error("continuous mode did not restart");
	a_sleep_finish: assert property (@(posedge ref_clk) disable iff (!resetn)
		is_sleep && conv_q == CV_RUN && !sys_clr |=> conv_q inside {CV_RUN, CV_PUSH})
		else $error("sleep cut a conversion short");
	a_wreg_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_en && wr_addr_q != `AUC_REG_NORESTART && conv_q == CV_RUN && !sys_clr
		|=> conv_q == CV_DLY)
		else $error("register write did not restart conversion");
	a_tx_frame: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(tx_q == TX_SEND) |-> !uart_tx)
		else $error("frame did not open with a low start bit");
	a_tx_idle_high: assert property (@(posedge ref_clk) disable iff (!resetn)
		tx_q == TX_IDLE && $past(tx_q) == TX_IDLE |-> uart_tx)
		else $error("transmit line low while idle");
	a_timeout_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		rx_q != RX_IDLE && to_cnt_q >= 17'(turbo_mode ? TIMEOUT_TURBO : TIMEOUT_NORM)
		|=> rx_q == RX_IDLE)
		else $error("interface not reset after timeout");
	a_ready_push: assert property (@(posedge ref_clk) disable iff (!resetn)
		fifo_push && fifo_in_ready && !fifo_pop && !sys_clr |=>
		!rdy_n_q ##1 (!rdy_n_q || $past(fifo_pop || sys_clr)))
		else $error("ready not asserted after a new result");

	c_two_results: cover property (@(posedge ref_clk) disable iff (!resetn)
		fifo_push ##[1:1000] conv_q == CV_RUN ##[1:1000] fifo_push);
	c_read_word: cover property (@(posedge ref_clk) disable iff (!resetn)
		is_rdata ##1 tx_q == TX_SEND);
	c_sleep: cover property (@(posedge ref_clk) disable iff (!resetn)
		sleep_pend_q ##1 conv_q == CV_OFF);
	c_timeout: cover property (@(posedge ref_clk) disable iff (!resetn)
		rx_q == RX_WAIT ##1 rx_q == RX_IDLE);

endmodule : auc_ctrl

// ### verif/auc_host.sv
// Host side of the UART link: frames bytes onto the receive line, collects reply bytes.
// Assumes the bench calls its tasks hierarchically and that both sides share ref_clk.
`timescale 1ns/1ps
module auc_host (
	input wire logic ref_clk,
	output logic rx_line,
	input wire logic tx_line
);
	int bit_len = 8;
	logic [7:0] got_q [$];

	// The receive line idles high between frames.
	initial rx_line = 1'b1;

	// One frame: low start, eight bits LSB first, high stop, each bit_len clocks long.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			rx_line = fr[i];
			repeat (bit_len - 1) @(negedge ref_clk);
		end
	endtask : send_byte

	// Every command goes out behind its own sync byte, so the device can retime each one.
	task automatic send_cmd(input logic [7:0] c);
		send_byte(8'h55);
		send_byte(c);
	endtask : send_cmd

	// Background receiver samples each reply bit near its middle; bad stop bits drop the byte.
	always begin : reply_side
		logic [7:0] b;
		@(negedge ref_clk);
		if (tx_line === 1'b0) begin
			repeat (bit_len / 2) @(negedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_len) @(negedge ref_clk);
				b[i] = tx_line;
			end
			repeat (bit_len) @(negedge ref_clk);
			if (tx_line === 1'b1) got_q.push_back(b);
		end
	end
endmodule : auc_host

// ### verif/auc_ctrl_tb.sv
// Bench for the converter control block: registers, conversion timing, buffer and resets.
// Assumes the host model drives the receive line and collects the reply bytes.
`timescale 1ns/1ps
module auc_ctrl_tb;
	typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} auc_row_s;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic reset_pin_n = 1'b1;
	logic [15:0] adc_result = 16'h8001;
	logic uart_rx, uart_tx, conversion_ready_n, shared_ready_pin, shared_ready_pin_oe;
	logic analog_on, modulator_tick, conversion_mode_bit, turbo_mode;
	logic [2:0] data_rate_field;
	logic [7:0] b0, b1;
	int miscompares = 0;
	int tests_run = 0;
	int n;
	// Address, written byte, byte read back; unmapped places read as zero.
	auc_row_s rows [7] = '{'{3'h0, 8'h5A, 8'h5A}, '{3'h2, 8'h33, 8'h33}, '{3'h3, 8'hC3, 8'hC3},
		'{3'h4, 8'h44, 8'h44}, '{3'h5, 8'h77, 8'h00}, '{3'h7, 8'h11, 8'h00},
		'{3'h1, 8'hB8, 8'hB8}};

	// Clock at 25 MHz.
	always #20 ref_clk = ~ref_clk;

	auc_host host (.ref_clk(ref_clk), .rx_line(uart_rx), .tx_line(uart_tx));

	// Short counts keep the run brief; the expectations below follow from them.
	auc_ctrl #(
		.POR_CYCLES(20),
		.TIMEOUT_NORM(50),
		.TIMEOUT_TURBO(50),
		.CONV_TICKS(4),
		.FIFO_DEPTH(8)
	) dut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.reset_pin_n(reset_pin_n),
		.uart_rx(uart_rx),
		.uart_tx(uart_tx),
		.adc_result(adc_result),
		.conversion_ready_n(conversion_ready_n),
		.shared_ready_pin(shared_ready_pin),
		.shared_ready_pin_oe(shared_ready_pin_oe),
		.analog_on(analog_on),
		.modulator_tick(modulator_tick),
		.conversion_mode_bit(conversion_mode_bit),
		.turbo_mode(turbo_mode),
		.data_rate_field(data_rate_field)
	);

	// Values are compared with case equality so that unknowns never match.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Cycle counts are compared against a window, since the latch point drifts by a clock.
	task automatic chk_in(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_in

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.send_cmd({4'h4, a, 1'b0});
		host.send_byte(d);
	endtask : wr

	// A missing reply turns into unknown data, which fails its compare.
	task automatic get(output logic [7:0] b);
		int k;
		k = 0;
		while (host.got_q.size() == 0 && k < 3000) begin
			@(negedge ref_clk);
			k++;
		end
		b = (host.got_q.size() > 0) ? host.got_q.pop_front() : 8'hxx;
	endtask : get

	task automatic rd_word(output logic [15:0] w);
		host.send_cmd(8'h10);
		get(b0);
		get(b1);
		w = {b1, b0};
	endtask : rd_word

	// Counts clocks while the ready line holds level v, bounded.
	task automatic lvl(input logic v, output int c);
		c = 0;
		while (conversion_ready_n === v && c < 3000) begin
			@(negedge ref_clk);
			c++;
		end
	endtask : lvl

	task automatic ticks(output int c);
		c = 0;
		repeat (40) begin
			@(negedge ref_clk);
			if (modulator_tick === 1'b1) c++;
		end
	endtask : ticks

	task automatic summarize();
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize

	// A hang counts as a mismatch and ends the run through the same closing task.
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		summarize();
	end

	initial begin
		logic [15:0] w;
		repeat (4) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({uart_tx, conversion_ready_n, analog_on, shared_ready_pin_oe}, 16'h000C);
		repeat (25) @(negedge ref_clk);
		ticks(n);
		chk_in(n, 10, 10);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			host.send_cmd({4'h2, rows[i].a, 1'b0});
			get(b0);
			chk(b0, rows[i].r);
		end
		chk({data_rate_field, turbo_mode, conversion_mode_bit, shared_ready_pin_oe,
			shared_ready_pin, analog_on}, 16'h00BE);
		ticks(n);
		chk_in(n, 20, 20);
		// Pin reset: a single low clock clears the configuration.
		reset_pin_n = 1'b0;
		@(negedge ref_clk);
		reset_pin_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({data_rate_field, turbo_mode, shared_ready_pin_oe}, 16'h0000);
		for (int c = 6; c < 8; c++) begin
			wr(3'h0, 8'h5A);
			host.send_cmd(8'(c));
			repeat (10) @(negedge ref_clk);
			host.send_cmd(8'h20);
			get(b0);
			chk(b0, 16'h0000);
		end
		// A write to register 2 mid-conversion restarts the long conversion.
		// A sleep sent while it runs must let it finish; the pin lags ready by a clock.
		wr(3'h4, 8'h48);
		host.send_cmd(8'h08);
		wr(3'h2, 8'h11);
		host.send_cmd(8'h02);
		lvl(1'b1, n);
		chk_in(n, 885, 896);
		repeat (3) @(negedge ref_clk);
		chk({shared_ready_pin_oe, shared_ready_pin}, 16'h0002);
		chk(analog_on, 16'h0000);
		rd_word(w);
		chk(w, 16'h8001);
		chk(conversion_ready_n, 16'h0001);
		wr(3'h1, 8'hD0);
		host.send_cmd(8'h09);
		lvl(1'b1, n);
		chk_in(n, 106, 117);
		rd_word(w);
		// Continuous run with no reads: ready pulses, then the buffer fills and stalls.
		wr(3'h1, 8'hC8);
		host.send_cmd(8'h08);
		lvl(1'b1, n);
		lvl(1'b0, n);
		lvl(1'b1, n);
		chk_in(n, 2, 2);
		repeat (400) @(negedge ref_clk);
		chk({analog_on, conversion_ready_n}, 16'h0002);
		adc_result = 16'h7FFF;
		host.send_cmd(8'h03);
		for (int i = 0; i < 9; i++) begin
			rd_word(w);
			chk(w, (i < 8) ? 16'h8001 : 16'h7FFF);
		end
		chk({analog_on, conversion_mode_bit}, 16'h0001);
		// A command left hanging after its sync byte is dropped after the idle timeout.
		host.bit_len = 12;
		host.send_byte(8'h55);
		repeat (300) @(negedge ref_clk);
		host.send_cmd(8'h28);
		get(b0);
		chk(b0, 16'h0048);
		host.send_cmd(8'h08);
		lvl(1'b1, n);
		chk_in(n, 20, 60);
		summarize();
	end
endmodule : auc_ctrl_tb
